// ===== core/ir_bridge_pkg.sv
// Shared constants for the infrared bridge start-up and host control ends
package ir_bridge_pkg;
  // Device clock and fixed line rate
  localparam int unsigned CLK_HZ        = 32'h017D_7840;
  localparam int unsigned HZ_PER_MHZ    = 32'h000F_4240;
  localparam int unsigned BAUD          = 32'h0000_2580;
  localparam int unsigned TICKS_PER_BIT = 32'h0000_0010;
  localparam int unsigned TICK_DIV_INT  = CLK_HZ / (BAUD * TICKS_PER_BIT);
  localparam logic [7:0]  TICK_DIV      = 8'(TICK_DIV_INT);

  // Start-up delays in microseconds, then in clock cycles
  // Cycles per microsecond first, so the product stays inside 32 bits
  localparam int unsigned PWRT_TIME_US  = 32'h0000_03E8;
  localparam int unsigned OST_TIME_US   = 32'h0000_0064;
  localparam int unsigned PWRT_CYCLES   = PWRT_TIME_US * (CLK_HZ / HZ_PER_MHZ);
  localparam int unsigned OST_CYCLES    = OST_TIME_US * (CLK_HZ / HZ_PER_MHZ);
  localparam logic [15:0] OST_LAST      = 16'(OST_CYCLES - 1);

  // Frame layout in bit-tick units
  localparam logic [3:0]  SAMPLE_TICK   = 4'h7;
  localparam logic [3:0]  LAST_TICK     = 4'hF;
  localparam logic [3:0]  STOP_INDEX    = 4'h9;
  localparam logic [3:0]  BIT_RESET     = 4'h0;
  localparam logic [8:0]  SHIFT_IDLE    = 9'h1FF;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;

  typedef enum logic [1:0] {
    ST_PWRT,
    ST_OST,
    ST_RUN
  } startup_state_t;
endpackage : ir_bridge_pkg

// ===== core/ir_bridge_if.sv
// Pin bundle between the host controller UART and the bridge
`timescale 1ns/10ps
`default_nettype none
interface ir_bridge_if;
  logic tx;
  logic rx;
  logic rts_n;
  logic cts_n;
  logic dsr_n;
  logic cd_n;

  modport dev (
    input  tx,
    input  rts_n,
    input  cd_n,
    output rx,
    output cts_n,
    output dsr_n
  );

  modport host (
    output tx,
    output rts_n,
    output cd_n,
    input  rx,
    input  cts_n,
    input  dsr_n
  );
endinterface : ir_bridge_if
`default_nettype wire

// ===== core/ir_bridge_dev.sv
// Bridge end: start-up sequencing, bit tick, host serial port and modem lines
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Fixed 9600 baud serial and infrared timing
// - Power-up delay first, then oscillator settle delay
// - Accept traffic only after both delays
// - Host and peer wait out start-up
// - Low reset holds everything idle
// - Reset release reruns sequence before operation
// - All timing comes from one clock
// - Supplied clock must match the baud rate
// - Host drives request-to-send low when ready
// - Request-to-send gates only local host flow
// - High carrier-detect means no carrier present
// - Data-set-ready follows own link state, gated by start-up
// - Sixteen bit ticks per bit period
// - Data-set-ready low while link is up and start-up is done
module ir_bridge_dev
  import ir_bridge_pkg::*;
#(
  parameter int unsigned PWRT_CYC = ir_bridge_pkg::PWRT_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  ir_bridge_if.dev        pins,
  input  wire logic       link_up,
  input  wire logic [7:0] send_byte,
  input  wire logic       send_valid,
  output logic            send_ready,
  output logic [7:0]      recv_byte,
  output logic            recv_valid,
  output logic            ready,
  output logic            link_cd
);
  import ir_bridge_pkg::*;

  localparam logic [15:0] PWRT_LAST = 16'(PWRT_CYC - 1);

  logic           rst_meta_n;
  logic           rst_sync_n;
  logic [2:0]     pin_meta;
  logic           tx_s;
  logic           rts_s;
  logic           cd_s;
  startup_state_t state;
  logic [15:0]    wait_cnt;
  logic           run;
  logic [7:0]     div_cnt;
  logic           bit_tick;
  logic           rx_busy;
  logic [3:0]     rx_cnt;
  logic [3:0]     rx_bit;
  logic [7:0]     rx_shift;
  logic           tx_busy;
  logic [3:0]     tx_cnt;
  logic [3:0]     tx_bit;
  logic [8:0]     tx_shift;
  logic           accept;

  // Reset asserts at once but leaves on a clock edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Pins from the host are asynchronous to this clock
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_meta <= 3'h7;
      tx_s     <= 1'b1;
      rts_s    <= 1'b1;
      cd_s     <= 1'b1;
    end else begin
      pin_meta <= {pins.cd_n, pins.rts_n, pins.tx};
      tx_s     <= pin_meta[0];
      rts_s    <= pin_meta[1];
      cd_s     <= pin_meta[2];
    end
  end

  // Start-up sequence restarts on every reset release
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state    <= ST_PWRT;
      wait_cnt <= 16'h0000;
    end else begin
      case (state)
        ST_PWRT: begin
          if (wait_cnt == PWRT_LAST) begin
            state    <= ST_OST;
            wait_cnt <= 16'h0000;
          end else begin
            wait_cnt <= wait_cnt + 16'h0001;
          end
        end
        ST_OST: begin
          if (wait_cnt == OST_LAST) begin
            state    <= ST_RUN;
            wait_cnt <= 16'h0000;
          end else begin
            wait_cnt <= wait_cnt + 16'h0001;
          end
        end
        ST_RUN: begin
          wait_cnt <= 16'h0000;
        end
        default: begin
          state    <= ST_PWRT;
          wait_cnt <= 16'h0000;
        end
      endcase
    end
  end

  assign run = (state == ST_RUN);

  // Bit tick runs freely from the device clock
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_cnt  <= 8'h00;
      bit_tick <= 1'b0;
    end else if (div_cnt == TICK_DIV - 8'h01) begin
      div_cnt  <= 8'h00;
      bit_tick <= 1'b1;
    end else begin
      div_cnt  <= div_cnt + 8'h01;
      bit_tick <= 1'b0;
    end
  end

  // Receiver samples mid-bit, eighth tick of sixteen
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_busy    <= 1'b0;
      rx_cnt     <= BIT_RESET;
      rx_bit     <= BIT_RESET;
      rx_shift   <= BYTE_RESET;
      recv_byte  <= BYTE_RESET;
      recv_valid <= 1'b0;
    end else begin
      recv_valid <= 1'b0;
      if (!rx_busy) begin
        if (run && !tx_s) begin
          rx_busy <= 1'b1;
          rx_cnt  <= BIT_RESET;
          rx_bit  <= BIT_RESET;
        end
      end else if (bit_tick) begin
        rx_cnt <= rx_cnt + 4'h1;
        if (rx_cnt == SAMPLE_TICK) begin
          rx_bit <= rx_bit + 4'h1;
          if (rx_bit == BIT_RESET) begin
            // A glitch shorter than half a bit is not a start bit
            rx_busy <= ~tx_s;
          end else if (rx_bit == STOP_INDEX) begin
            rx_busy    <= 1'b0;
            recv_byte  <= rx_shift;
            recv_valid <= tx_s;
          end else begin
            rx_shift <= {tx_s, rx_shift[7:1]};
          end
        end
      end
    end
  end

  assign accept = send_valid && send_ready;

  // Transmitter to the host; the local request-to-send and the start-up state gate it
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_busy    <= 1'b0;
      tx_cnt     <= BIT_RESET;
      tx_bit     <= BIT_RESET;
      tx_shift   <= SHIFT_IDLE;
      send_ready <= 1'b0;
    end else if (accept) begin
      tx_busy    <= 1'b1;
      tx_cnt     <= BIT_RESET;
      tx_bit     <= BIT_RESET;
      tx_shift   <= {send_byte, 1'b0};
      send_ready <= 1'b0;
    end else begin
      send_ready <= run && !tx_busy && !rts_s;
      if (tx_busy && bit_tick) begin
        tx_cnt <= tx_cnt + 4'h1;
        if (tx_cnt == LAST_TICK) begin
          tx_bit   <= tx_bit + 4'h1;
          tx_shift <= {1'b1, tx_shift[8:1]};
          if (tx_bit == STOP_INDEX) begin
            tx_busy <= 1'b0;
          end
        end
      end
    end
  end

  // Modem outputs are all registered
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pins.rx    <= 1'b1;
      pins.cts_n <= 1'b1;
      pins.dsr_n <= 1'b1;
      ready      <= 1'b0;
      link_cd    <= 1'b0;
    end else begin
      pins.rx    <= tx_busy ? tx_shift[0] : 1'b1;
      pins.cts_n <= ~run;
      pins.dsr_n <= ~(run && link_up);
      ready      <= run;
      link_cd    <= run && !cd_s;
    end
  end
endmodule : ir_bridge_dev
`default_nettype wire

// ===== core/ir_bridge_host.sv
// Host controller end: serial port, request-to-send and carrier-detect driving
`timescale 1ns/10ps
`default_nettype none
module ir_bridge_host
  import ir_bridge_pkg::*;
#(
  parameter int unsigned WAIT_CYC = ir_bridge_pkg::PWRT_CYCLES + ir_bridge_pkg::OST_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  ir_bridge_if.host       pins,
  input  wire logic       can_accept,
  input  wire logic       carrier,
  input  wire logic [7:0] send_byte,
  input  wire logic       send_valid,
  output logic            send_ready,
  output logic [7:0]      recv_byte,
  output logic            recv_valid,
  output logic            link_seen
);
  import ir_bridge_pkg::*;

  localparam logic [15:0] WAIT_LAST = 16'(WAIT_CYC - 1);

  logic [2:0]  pin_meta;
  logic        rx_s;
  logic        cts_s;
  logic        dsr_s;
  logic [15:0] wait_cnt;
  logic        waited;
  logic [7:0]  div_cnt;
  logic        bit_tick;
  logic        rx_busy;
  logic [3:0]  rx_cnt;
  logic [3:0]  rx_bit;
  logic [7:0]  rx_shift;
  logic        tx_busy;
  logic [3:0]  tx_cnt;
  logic [3:0]  tx_bit;
  logic [8:0]  tx_shift;
  logic        accept;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta  <= 3'h7;
      rx_s      <= 1'b1;
      cts_s     <= 1'b1;
      dsr_s     <= 1'b1;
      link_seen <= 1'b0;
    end else begin
      pin_meta  <= {pins.dsr_n, pins.cts_n, pins.rx};
      rx_s      <= pin_meta[0];
      cts_s     <= pin_meta[1];
      dsr_s     <= pin_meta[2];
      link_seen <= ~dsr_s;
    end
  end

  // Stay off the line until the bridge has finished starting up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 16'h0000;
      waited   <= 1'b0;
    end else if (!waited) begin
      waited   <= (wait_cnt == WAIT_LAST);
      wait_cnt <= wait_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt  <= 8'h00;
      bit_tick <= 1'b0;
    end else if (div_cnt == TICK_DIV - 8'h01) begin
      div_cnt  <= 8'h00;
      bit_tick <= 1'b1;
    end else begin
      div_cnt  <= div_cnt + 8'h01;
      bit_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_busy    <= 1'b0;
      rx_cnt     <= BIT_RESET;
      rx_bit     <= BIT_RESET;
      rx_shift   <= BYTE_RESET;
      recv_byte  <= BYTE_RESET;
      recv_valid <= 1'b0;
    end else begin
      recv_valid <= 1'b0;
      if (!rx_busy) begin
        if (!rx_s) begin
          rx_busy <= 1'b1;
          rx_cnt  <= BIT_RESET;
          rx_bit  <= BIT_RESET;
        end
      end else if (bit_tick) begin
        rx_cnt <= rx_cnt + 4'h1;
        if (rx_cnt == SAMPLE_TICK) begin
          rx_bit <= rx_bit + 4'h1;
          if (rx_bit == BIT_RESET) begin
            rx_busy <= ~rx_s;
          end else if (rx_bit == STOP_INDEX) begin
            rx_busy    <= 1'b0;
            recv_byte  <= rx_shift;
            recv_valid <= rx_s;
          end else begin
            rx_shift <= {rx_s, rx_shift[7:1]};
          end
        end
      end
    end
  end

  assign accept = send_valid && send_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy    <= 1'b0;
      tx_cnt     <= BIT_RESET;
      tx_bit     <= BIT_RESET;
      tx_shift   <= SHIFT_IDLE;
      send_ready <= 1'b0;
    end else if (accept) begin
      tx_busy    <= 1'b1;
      tx_cnt     <= BIT_RESET;
      tx_bit     <= BIT_RESET;
      tx_shift   <= {send_byte, 1'b0};
      send_ready <= 1'b0;
    end else begin
      send_ready <= waited && !tx_busy && !cts_s;
      if (tx_busy && bit_tick) begin
        tx_cnt <= tx_cnt + 4'h1;
        if (tx_cnt == LAST_TICK) begin
          tx_bit   <= tx_bit + 4'h1;
          tx_shift <= {1'b1, tx_shift[8:1]};
          if (tx_bit == STOP_INDEX) begin
            tx_busy <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins.tx    <= 1'b1;
      pins.rts_n <= 1'b1;
      pins.cd_n  <= 1'b1;
    end else begin
      pins.tx    <= tx_busy ? tx_shift[0] : 1'b1;
      pins.rts_n <= ~can_accept;
      pins.cd_n  <= ~carrier;
    end
  end
endmodule : ir_bridge_host
`default_nettype wire

// ===== verif/ir_bridge_props.sv
// Pin bundle checks for the bridge and host ends
`timescale 1ns/10ps
`default_nettype none
module ir_bridge_props
  import ir_bridge_pkg::*;
#(
  parameter int unsigned PWRT_CYC = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx,
  input wire logic rx,
  input wire logic rts_n,
  input wire logic cts_n,
  input wire logic dsr_n
);
  localparam int unsigned START = 2 + PWRT_CYC + OST_CYCLES;
  logic [15:0] up;
  logic [15:0] rx_age;
  logic [15:0] rx_low;
  logic        rx_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Saturates so a long run never wraps into the start-up window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up <= 16'h0000;
    end else if (up != 16'hFFFF) begin
      up <= up + 16'h0001;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_q   <= 1'b1;
      rx_age <= 16'h0000;
      rx_low <= 16'h0000;
    end else begin
      rx_q   <= rx;
      rx_age <= (rx != rx_q) ? 16'h0001 : rx_age + {15'h0000, rx_age != 16'hFFFF};
      rx_low <= rx ? 16'h0000 : rx_low + 16'h0001;
    end
  end
  sequence rx_start;
    $fell(rx);
  endsequence
  sequence run_entry;
    $fell(cts_n);
  endsequence
  reset_idle_a: assert property ($rose(rst_n) |-> rx && cts_n && dsr_n)
    else $error("outputs not idle at reset release");
  cts_start_a: assert property (run_entry |-> up >= START - 1 && up <= START + 3)
    else $error("run entered at wrong cycle");
  cts_hold_a: assert property (!cts_n |=> !cts_n)
    else $error("run state left without reset");
  dsr_run_a: assert property (!dsr_n |-> up >= START - 1)
    else $error("link reported before start-up done");
  rx_gate_a: assert property (cts_n |-> rx)
    else $error("bridge sent before start-up done");
  tx_gate_a: assert property (cts_n |-> tx)
    else $error("host sent before start-up done");
  rx_rts_a: assert property (rx_start |-> $past(rts_n, 5) == 1'b0)
    else $error("bridge sent while host not ready");
  rx_width_a: assert property (rx != rx_q |-> rx_age >= 16'h097E)
    else $error("bit shorter than fifteen ticks");
  rx_low_a: assert property (rx_low <= 16'h5B28)
    else $error("line low longer than nine bits");
endmodule : ir_bridge_props
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench joining bridge and host ends
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ir_bridge_pkg::*;
  localparam int unsigned PW    = 20;
  localparam int unsigned START = 2 + PW + OST_CYCLES;
  localparam int unsigned BITC  = 16 * TICK_DIV_INT;
  logic       clk;
  logic       rst_n;
  logic       link_up;
  logic       can_accept;
  logic       carrier;
  logic [7:0] d_tb;
  logic       d_tv;
  logic       d_tr;
  logic [7:0] d_rb;
  logic       d_rv;
  logic       ready;
  logic       link_cd;
  logic [7:0] h_tb;
  logic       h_tv;
  logic       h_tr;
  logic [7:0] h_rb;
  logic       h_rv;
  logic       link_seen;
  int         error_cnt;
  int         tests_run;
  ir_bridge_if pins ();
  ir_bridge_dev #(.PWRT_CYC(PW)) u_ir_bridge_dev (.clk(clk), .rst_n(rst_n), .pins(pins), .link_up(link_up),
    .send_byte(d_tb), .send_valid(d_tv), .send_ready(d_tr), .recv_byte(d_rb), .recv_valid(d_rv),
    .ready(ready), .link_cd(link_cd));
  ir_bridge_host #(.WAIT_CYC(40)) u_ir_bridge_host (.clk(clk), .rst_n(rst_n), .pins(pins),
    .can_accept(can_accept), .carrier(carrier), .send_byte(h_tb), .send_valid(h_tv), .send_ready(h_tr),
    .recv_byte(h_rb), .recv_valid(h_rv), .link_seen(link_seen));
  ir_bridge_props #(.PWRT_CYC(PW)) u_props (.clk(clk), .rst_n(rst_n), .tx(pins.tx), .rx(pins.rx),
    .rts_n(pins.rts_n), .cts_n(pins.cts_n), .dsr_n(pins.dsr_n));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  task automatic t_startup();
    int n;
    n = 0;
    check("cts_n", pins.cts_n, 1);
    while (ready !== 1'b1 && n < START + 9) begin
      @(negedge clk);
      n++;
    end
    check("startup", n >= START - 1 && n <= START + 3, 1);
    check("cts_n", pins.cts_n, 0);
    $display("test startup done");
  endtask : t_startup
  task automatic t_modem();
    carrier = 1;
    repeat (5) @(negedge clk);
    check("cd_n", pins.cd_n, 0);
    check("link_cd", link_cd, 1);
    check("dsr_n", pins.dsr_n, 1);
    link_up = 1;
    carrier = 0;
    repeat (5) @(negedge clk);
    check("link_cd", link_cd, 0);
    check("dsr_n", pins.dsr_n, 0);
    check("link_seen", link_seen, 1);
    link_up = 0;
    repeat (2) @(negedge clk);
    check("dsr_n", pins.dsr_n, 1);
    $display("test modem done");
  endtask : t_modem
  // Both directions at once: the host link is full duplex
  task automatic t_duplex(input logic [7:0] a, input logic [7:0] b);
    int n;
    int t0;
    logic [1:0] got;
    logic ht;
    logic dt;
    n = 0;
    t0 = 0;
    got = 2'b00;
    h_tb = a;
    d_tb = b;
    h_tv = 1;
    d_tv = 1;
    // A ready that already stands takes the byte at the coming edge
    ht = h_tr === 1'b1;
    dt = d_tr === 1'b1;
    while (got != 2'b11 && n < 12 * BITC) begin
      @(negedge clk);
      n++;
      if (ht) h_tv = 0;
      if (dt) d_tv = 0;
      ht = h_tr === 1'b1 && h_tv;
      dt = d_tr === 1'b1 && d_tv;
      if (ht) t0 = n;
      if (d_rv === 1'b1) begin
        check("dev byte", d_rb, a);
        check("frame", n - t0 >= 9 * BITC && n - t0 <= 10 * BITC, 1);
        got[0] = 1;
      end
      if (h_rv === 1'b1) begin
        check("host byte", h_rb, b);
        got[1] = 1;
      end
    end
    check("both", got, 2'b11);
    $display("test duplex done");
  endtask : t_duplex
  task automatic t_stall();
    logic seen;
    seen = 0;
    can_accept = 0;
    // Request-to-send needs four edges to reach the bridge's send gate
    repeat (4) @(negedge clk);
    d_tb = 8'h81;
    d_tv = 1;
    repeat (2 * BITC) begin
      @(negedge clk);
      seen = seen | d_tr | ~pins.rx;
    end
    check("stalled", seen, 0);
    can_accept = 1;
    t_duplex(8'h5A, 8'h81);
    $display("test stall done");
  endtask : t_stall
  task automatic t_reset();
    link_up = 1;
    carrier = 1;
    repeat (4) @(negedge clk);
    rst_n = 0;
    @(negedge clk);
    check("rx", pins.rx, 1);
    check("cts_n", pins.cts_n, 1);
    check("dsr_n", pins.dsr_n, 1);
    check("ready", ready, 0);
    check("link_cd", link_cd, 0);
    repeat (3) @(negedge clk);
    rst_n = 1;
    t_startup();
    check("dsr_n", pins.dsr_n, 0);
    $display("test reset done");
  endtask : t_reset
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // Longest path is two frame pairs, a two-bit stall and two start-ups
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    finish_test();
  end
  initial begin
    error_cnt = 0;
    tests_run = 0;
    rst_n = 0;
    link_up = 0;
    can_accept = 1;
    carrier = 0;
    d_tb = 8'h00;
    d_tv = 0;
    h_tb = 8'h00;
    h_tv = 0;
    repeat (4) @(negedge clk);
    rst_n = 1;
    t_startup();
    t_modem();
    t_stall();
    t_duplex(8'hA5, 8'h00);
    t_reset();
    finish_test();
  end
endmodule : tb
`default_nettype wire
